// >>> logic/spsc_pkg.sv
// Behaviour
// - The serial port sends and receives 19200 baud characters with 8 data bits, no parity, 1 stop bit.
// - No flow control is used; characters are taken with no handshake.
// - A valid command byte is sent back unchanged to its sender (the code drops it if a newer command comes before its send starts).
// - Bytes 0x10 to 0x1F select computer port byte minus 0x0F, ports 1 to 16.
// - Byte 0x71 selects channel zero: no port connected and video off.
// - Each channel switch sends the command byte of the new channel on the serial port (the code drops it if a newer switch comes before its send starts).
// - The same command bytes a switching unit emits make this unit follow it.
package spsc_pkg;
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned BAUD_BPS = 19200;
  localparam int unsigned BIT_CYC = (CLK_HZ + BAUD_BPS / 2) / BAUD_BPS;
  localparam int unsigned DATA_BITS = 8;
  localparam logic [7:0] CMD_PORT_LO = 8'h10;
  localparam logic [7:0] CMD_PORT_HI = 8'h1F;
  localparam logic [7:0] CMD_VIDEO_OFF = 8'h71;
  localparam logic [4:0] CHAN_NONE = 5'h00;
  localparam logic [7:0] PORT_BASE = 8'h0F;

  typedef struct packed {
    logic [4:0] chan;
    logic video_on;
  } spsc_sel_s;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } spsc_rx_e;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h1,
    TX_SHIFT = 3'h2,
    TX_STOP = 3'h4
  } spsc_tx_e;
endpackage

// >>> logic/spsc_top.sv
`timescale 1ns/10ps
`default_nettype none
module spsc_top #(
  parameter int unsigned BIT_CYCLES = spsc_pkg::BIT_CYC
) (
  input wire logic clock_i, // 250 MHz system clock
  input wire logic srst_i, // synchronous reset, active high
  input wire logic rxd_i, // serial data in, idle high
  output logic txd_o, // serial data out, idle high
  output spsc_pkg::spsc_sel_s sel_o, // selected channel and video enable
  output logic rx_err_o // one-cycle pulse on bad stop bit
);
  import spsc_pkg::*;

  localparam int unsigned CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] FULL_BIT = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF_BIT = CW'(BIT_CYCLES / 2 - 1);
  localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);

  // input is already synchronous; one register still cleans the edge timing
  logic rxd_reg;
  spsc_rx_e rx_st_reg, rx_st_next;
  logic [CW-1:0] rx_cnt_reg, rx_cnt_next;
  logic [2:0] rx_bit_reg, rx_bit_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic rx_done_reg, rx_done_next;
  logic rx_err_reg, rx_err_next;

  always_comb begin
    rx_st_next = rx_st_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rx_done_next = 1'b0;
    rx_err_next = 1'b0;
    case (rx_st_reg)
      RX_IDLE: begin
        if (!rxd_reg) begin // no handshake, any falling edge starts a frame
          rx_st_next = RX_START;
          rx_cnt_next = HALF_BIT;
        end
      end
      RX_START: begin
        if (rx_cnt_reg != '0) begin
          rx_cnt_next = rx_cnt_reg - 1'b1;
        end else if (rxd_reg) begin
          rx_st_next = RX_IDLE; // glitch, not a start bit
        end else begin
          rx_st_next = RX_DATA;
          rx_cnt_next = FULL_BIT;
          rx_bit_next = '0;
        end
      end
      RX_DATA: begin
        if (rx_cnt_reg != '0) begin
          rx_cnt_next = rx_cnt_reg - 1'b1;
        end else begin
          rx_sh_next = {rxd_reg, rx_sh_reg[7:1]}; // lsb first
          rx_cnt_next = FULL_BIT;
          rx_bit_next = rx_bit_reg + 1'b1;
          if (rx_bit_reg == LAST_BIT) begin
            rx_st_next = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_cnt_reg != '0) begin
          rx_cnt_next = rx_cnt_reg - 1'b1;
        end else begin
          rx_st_next = RX_IDLE;
          rx_done_next = rxd_reg; // bad stop bit drops the byte
          rx_err_next = !rxd_reg;
        end
      end
      default: rx_st_next = RX_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rxd_reg <= 1'b1;
      rx_st_reg <= RX_IDLE;
      rx_cnt_reg <= '0;
      rx_bit_reg <= '0;
      rx_sh_reg <= '0;
      rx_done_reg <= 1'b0;
      rx_err_reg <= 1'b0;
    end else begin
      rxd_reg <= rxd_i;
      rx_st_reg <= rx_st_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      rx_done_reg <= rx_done_next;
      rx_err_reg <= rx_err_next;
    end
  end

  // decode and channel select
  logic is_port, is_off, cmd_ok;
  spsc_sel_s sel_reg, sel_next;
  logic echo_pend_reg, echo_pend_next;
  logic [7:0] echo_byte_reg, echo_byte_next;
  logic tx_take;

  assign is_port = (rx_sh_reg >= CMD_PORT_LO) && (rx_sh_reg <= CMD_PORT_HI);
  assign is_off = (rx_sh_reg == CMD_VIDEO_OFF);
  assign cmd_ok = rx_done_reg && (is_port || is_off);

  always_comb begin
    sel_next = sel_reg;
    echo_pend_next = echo_pend_reg && !tx_take;
    echo_byte_next = echo_byte_reg;
    if (cmd_ok) begin // other codes fall through untouched
      if (is_port) begin
        sel_next.chan = 5'(rx_sh_reg - PORT_BASE);
        sel_next.video_on = 1'b1;
      end else begin
        sel_next.chan = CHAN_NONE;
        sel_next.video_on = 1'b0;
      end
      // the echo and the switch announce are the same byte, so one send covers both
      echo_pend_next = 1'b1;
      echo_byte_next = rx_sh_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sel_reg <= '{chan: CHAN_NONE, video_on: 1'b0};
      echo_pend_reg <= 1'b0;
      echo_byte_reg <= '0;
    end else begin
      sel_reg <= sel_next;
      echo_pend_reg <= echo_pend_next;
      echo_byte_reg <= echo_byte_next;
    end
  end

  // transmitter; a newer command overwrites an echo not yet started
  spsc_tx_e tx_st_reg, tx_st_next;
  logic [CW-1:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic [8:0] tx_sh_reg, tx_sh_next;
  logic txd_reg, txd_next;

  assign tx_take = (tx_st_reg == TX_IDLE) && echo_pend_reg;

  always_comb begin
    tx_st_next = tx_st_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    txd_next = txd_reg;
    case (tx_st_reg)
      TX_IDLE: begin
        txd_next = 1'b1;
        if (echo_pend_reg) begin
          tx_st_next = TX_SHIFT;
          tx_sh_next = {echo_byte_reg, 1'b0}; // start bit then lsb first
          tx_bit_next = '0;
          tx_cnt_next = FULL_BIT;
          txd_next = 1'b0;
        end
      end
      TX_SHIFT: begin
        if (tx_cnt_reg != '0) begin
          tx_cnt_next = tx_cnt_reg - 1'b1;
        end else begin
          tx_cnt_next = FULL_BIT;
          tx_sh_next = {1'b1, tx_sh_reg[8:1]};
          txd_next = tx_sh_reg[1];
          tx_bit_next = tx_bit_reg + 1'b1;
          if (tx_bit_reg == 4'(DATA_BITS)) begin
            tx_st_next = TX_STOP;
            txd_next = 1'b1; // single stop bit
          end
        end
      end
      TX_STOP: begin
        if (tx_cnt_reg != '0) begin
          tx_cnt_next = tx_cnt_reg - 1'b1;
        end else begin
          tx_st_next = TX_IDLE;
        end
      end
      default: tx_st_next = TX_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tx_st_reg <= TX_IDLE;
      tx_cnt_reg <= '0;
      tx_bit_reg <= '0;
      tx_sh_reg <= '1;
      txd_reg <= 1'b1;
    end else begin
      tx_st_reg <= tx_st_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg <= tx_sh_next;
      txd_reg <= txd_next;
    end
  end

  assign txd_o = txd_reg;
  assign sel_o = sel_reg;
  assign rx_err_o = rx_err_reg;

  port_sel_a: assert property (@(posedge clock_i) disable iff (srst_i)
    rx_done_reg && is_port |=> sel_o.chan == 5'($past(rx_sh_reg) - PORT_BASE) && sel_o.video_on)
    else $error("port command did not select its port");
  video_off_a: assert property (@(posedge clock_i) disable iff (srst_i)
    rx_done_reg && is_off |=> sel_o.chan == CHAN_NONE && !sel_o.video_on)
    else $error("video off command not applied");
  bad_cmd_a: assert property (@(posedge clock_i) disable iff (srst_i)
    rx_done_reg && !is_port && !is_off && !echo_pend_reg |=> $stable(sel_o) && !echo_pend_reg)
    else $error("invalid byte changed state");
  echo_arm_a: assert property (@(posedge clock_i) disable iff (srst_i)
    cmd_ok |=> echo_pend_reg && echo_byte_reg == $past(rx_sh_reg))
    else $error("valid command not queued for echo");
  switch_tx_a: assert property (@(posedge clock_i) disable iff (srst_i)
    $changed(sel_o) |-> echo_pend_reg || tx_st_reg == TX_SHIFT)
    else $error("channel switch without transmit");
  stop_drop_a: assert property (@(posedge clock_i) disable iff (srst_i)
    rx_st_reg == RX_STOP && rx_cnt_reg == '0 && !rxd_reg |=> !rx_done_reg ##1 $stable(sel_o))
    else $error("bad stop bit byte decoded");
  tx_start_a: assert property (@(posedge clock_i) disable iff (srst_i)
    tx_take |=> !txd_o [*8])
    else $error("start bit too short");
  idle_line_a: assert property (@(posedge clock_i) disable iff (srst_i)
    tx_st_reg == TX_IDLE && !echo_pend_reg |=> txd_o)
    else $error("line not idle high");
endmodule
`default_nettype wire

// >>> verification/serial_port_switch_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module serial_port_switch_control_bench;
  import spsc_pkg::*;
  localparam int unsigned BITC = 16;
  typedef struct packed {
    logic [7:0] cmd;
    logic [4:0] chan;
    logic echo;
  } spsc_row_s;
  // ignored bytes leave the previous channel in place
  spsc_row_s rows [9] = '{'{8'h10, 5'h01, 1'b1}, '{8'h1F, 5'h10, 1'b1}, '{8'h20, 5'h10, 1'b0},
    '{8'h15, 5'h06, 1'b1}, '{8'h0F, 5'h06, 1'b0}, '{8'h71, 5'h00, 1'b1},
    '{8'h72, 5'h00, 1'b0}, '{8'h1A, 5'h0B, 1'b1}, '{8'h1A, 5'h0B, 1'b1}};
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic rxd;
  logic txd;
  logic rx_err;
  spsc_sel_s sel;
  int err_count = 0;
  int n_checks = 0;
  int err_seen = 0;
  int c0;
  always #2 clock_i = ~clock_i;
  // pulse is looked at mid-cycle, away from the edge that launches it
  always @(negedge clock_i) if (rx_err === 1'b1) err_seen++;
  spsc_top #(.BIT_CYCLES(BITC)) dut_u (.clock_i(clock_i), .srst_i(srst_i), .rxd_i(rxd),
    .txd_o(txd), .sel_o(sel), .rx_err_o(rx_err));
  spsc_host #(.BITC(BITC)) host_u (.clock_i(clock_i), .line_i(txd), .line_o(rxd));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // fixed wait covers decode, the 3-edge launch and the whole echo frame
  task automatic run(input logic [7:0] b, input logic stop);
    host_u.send(b, stop);
    repeat (BITC * 14) @(negedge clock_i);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clock_i);
    check("txd_reset", {7'h00, txd}, 8'h01);
    check("sel_reset", {2'h0, sel}, 8'h00);
    check("err_reset", {7'h00, rx_err}, 8'h00);
    $display("reset done");
    srst_i = 1'b0;
    foreach (rows[i]) begin
      c0 = host_u.rx_cnt;
      run(rows[i].cmd, 1'b1);
      check("chan", {3'h0, sel.chan}, {3'h0, rows[i].chan});
      check("video", {7'h00, sel.video_on}, {7'h00, rows[i].chan != 5'h00});
      check("echo_count", 8'(host_u.rx_cnt - c0), {7'h00, rows[i].echo});
      if (rows[i].echo) check("echo", host_u.rx_byte, rows[i].cmd);
      $display("row %0d done", i);
    end
    c0 = host_u.rx_cnt;
    run(8'h12, 1'b0);
    check("bad_stop_chan", {3'h0, sel.chan}, 8'h0B);
    check("bad_stop_pulse", 8'(err_seen), 8'h01);
    check("bad_stop_echo", 8'(host_u.rx_cnt - c0), 8'h00);
    $display("bad stop done");
    c0 = host_u.rx_cnt;
    host_u.send(8'h13, 1'b1);
    run(8'h14, 1'b1);
    check("b2b_chan", {3'h0, sel.chan}, 8'h05);
    check("b2b_echo", host_u.rx_byte, 8'h14);
    check("b2b_count", 8'(host_u.rx_cnt - c0), 8'h02);
    $display("back to back done");
    srst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    check("sel_rereset", {2'h0, sel}, 8'h00);
    check("txd_rereset", {7'h00, txd}, 8'h01);
    srst_i = 1'b0;
    $display("second reset done");
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire

// >>> verification/spsc_host.sv
`timescale 1ns/10ps
`default_nettype none
module spsc_host #(
  parameter int unsigned BITC = 16
) (
  input wire logic clock_i, // bench clock
  input wire logic line_i, // characters coming back from the switch
  output logic line_o // commands towards the switch
);
  logic [7:0] rx_byte;
  int rx_cnt;
  initial begin
    line_o = 1'b1;
    rx_byte = 8'h00;
    rx_cnt = 0;
  end
  // same frame as the switch, sent blind with no handshake
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clock_i);
      line_o = f[i];
      repeat (BITC - 1) @(negedge clock_i);
    end
    @(negedge clock_i);
    line_o = 1'b1;
  endtask
  // mid-bit sampling, lsb first; frames with a low stop are not counted
  always begin : rx_proc
    logic [7:0] sh;
    @(negedge line_i);
    repeat (BITC / 2) @(posedge clock_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BITC) @(posedge clock_i);
      sh[i] = line_i;
    end
    repeat (BITC) @(posedge clock_i);
    if (line_i === 1'b1) begin
      rx_byte = sh;
      rx_cnt++;
    end
  end
endmodule
`default_nettype wire
